// *** hdl/mm_ctl_if.sv ***
// Waveform rate selection and update tick between top and divider.
`timescale 1ns/1ps
interface mm_ctl_if;
    logic [1:0] rate_sel;
    logic       tick;
    modport ctl (output rate_sel, input  tick);
    modport div (input  rate_sel, output tick);
endinterface

// *** hdl/mm_hold_timer.sv ***
// One-shot timer holding a busy level for a fixed number of cycles.
`timescale 1ns/1ps
module mm_hold_timer #(
    parameter int CYCLES = 900
) (
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    input  wire logic i_start,
    output logic      o_busy
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic          busy_r;

    initial begin
        if (CYCLES < 1) $error("mm_hold_timer: CYCLES must be at least 1");
    end

    assign o_busy = busy_r;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
        end else if (i_start) begin
            cnt_r  <= CW'(CYCLES - 1);
            busy_r <= 1'b1;
        end else if (cnt_r != '0) begin
            cnt_r  <= cnt_r - CW'(1);
        end else begin
            busy_r <= 1'b0;
        end
    end

endmodule

// *** hdl/mm_mode_top.sv ***
// Operating configuration register with its serial access and controls.
//
// How it works
// RULE_01: Every controlled function follows the value written into the operating configuration register at address 06H.
// RULE_02: Bit 0 set bypasses the current channel high-pass filter, clear keeps it active.
// RULE_03: The host writes zero to factory test bit 1; the block stores it and gives it no function.
// RULE_04: Bit 2 set silences the power-proportional pulse output, clear lets pulses through.
// RULE_05: Bit 3 set suppresses all line dip events for as long as it stays set.
// RULE_06: Writing one to bit 5 starts a temperature conversion and the bit clears itself when it completes; a write that also sets bit 6 starts none.
// RULE_07: Writing one to bit 6 resets the chip, and no serial transfer is accepted for 18 us afterwards.
// RULE_08: Bit 7 selects calibration mode when set and normal measurement when clear.
// RULE_09: Bit 8 set shorts the two inputs of converter 1 together.
// RULE_10: Bit 9 set shorts the two inputs of converter 2 together.
// RULE_11: Bit 10 set exchanges the two analog channels between the converters.
// RULE_12: Bits 12:11 set the waveform update rate to the clock divided by 128, 256, 512 or 1024.
// RULE_13: Bits 14:13 choose which sampled signal is loaded into the waveform register at each update.
// RULE_14: Source code 00 is filtered active power, 01 reserved, 10 channel 1 and 11 channel 2.
// RULE_15: The host writes zero to factory test bit 15; the block stores it and gives it no function.
// RULE_16: Each access opens with a command byte holding a write flag and a five-bit address, then the data follows.
// RULE_17: Reserved bit 4 is stored as written and controls nothing.
`timescale 1ns/1ps
module mm_mode_top #(
    parameter int SAMPLE_W     = 24,
    parameter int SOFT_RST_CYC = mm_pkg::MM_SOFT_RST_CYC
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_sclk,
    input  wire logic                i_sdin,
    input  wire logic                i_cs_n,
    output logic                     o_sdout,
    input  wire logic                i_thermal_done,
    input  wire logic                i_power_pulse,
    input  wire logic                i_dip_raw,
    input  wire logic [SAMPLE_W-1:0] i_power_sample,
    input  wire logic [SAMPLE_W-1:0] i_chan1_sample,
    input  wire logic [SAMPLE_W-1:0] i_chan2_sample,
    output logic                     o_hp_filter_bypass,
    output logic                     o_power_freq_output,
    output logic                     o_dip_event,
    output logic                     o_thermal_start,
    output logic                     o_soft_chip_reset,
    output logic                     o_calibration_select,
    output logic                     o_conv1_inputs_shorted,
    output logic                     o_conv2_inputs_shorted,
    output logic                     o_channel_swap,
    output logic [SAMPLE_W-1:0]      o_waveform,
    output logic                     o_waveform_new
);
    import mm_pkg::*;

    initial begin
        if (SAMPLE_W < 1 || SAMPLE_W > 32)
            $error("mm_mode_top: SAMPLE_W must be 1 to 32");
        if (SOFT_RST_CYC < 1)
            $error("mm_mode_top: SOFT_RST_CYC must be at least 1");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mm_state_t             state_r;
    mm_state_t             state_nxt;
    logic [15:0]           mode_r;
    logic [15:0]           mode_nxt;
    logic [15:0]           shift_r;
    logic [15:0]           tx_r;
    logic [4:0]            bits_r;
    logic                  cmd_wr_r;
    logic [4:0]            cmd_addr_r;
    logic                  sclk_q_r;
    logic                  sdout_r;
    logic                  pulse_r;
    logic                  dip_r;
    logic                  start_r;
    logic                  wave_new_r;
    logic [SAMPLE_W-1:0]   wave_r;
    logic                  rise;
    logic                  fall;
    logic                  cmd_done;
    logic                  data_done;
    logic [15:0]           word_in;
    logic [7:0]            cmd_in;
    logic                  mode_hit;
    logic                  mode_write;
    logic                  go_thermal;
    logic                  go_reset;
    logic                  rst_busy;
    logic                  src_load;
    logic [SAMPLE_W-1:0]   src_sample;
    logic [1:0]            src_sel;
    logic [1:0]            rate_sel;

    mm_ctl_if ctl ();

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    // Inputs are synchronous, so one stage suffices for edge finding.
    // Frames are discarded while the soft reset is in progress.
    assign rise      = i_sclk & ~sclk_q_r & ~i_cs_n & ~rst_busy;
    assign fall      = ~i_sclk & sclk_q_r & ~i_cs_n & ~rst_busy;
    assign word_in   = {shift_r[14:0], i_sdin};
    assign cmd_in    = word_in[7:0];
    assign cmd_done  = rise && (state_r == MM_ST_CMD)
                       && (bits_r == 5'(MM_CMD_BITS - 1));  // RULE_16
    assign data_done = rise && (state_r == MM_ST_DATA)
                       && (bits_r == 5'(MM_DATA_BITS - 1));
    assign mode_hit  = (cmd_addr_r == MM_ADDR_MODE);
    assign mode_write = data_done & cmd_wr_r & mode_hit;  // RULE_16

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MM_ST_CMD: begin
                if (cmd_done) begin
                    state_nxt = MM_ST_DATA;
                end
            end
            MM_ST_DATA: begin
                if (data_done) begin
                    state_nxt = MM_ST_IGNORE;
                end
            end
            // Surplus bits are dropped until the frame closes.
            MM_ST_IGNORE: begin
                state_nxt = MM_ST_IGNORE;
            end
            default: begin
                state_nxt = MM_ST_CMD;
            end
        endcase
        if (i_cs_n || rst_busy) begin
            state_nxt = MM_ST_CMD;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r  <= MM_ST_CMD;
            sclk_q_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            sclk_q_r <= i_sclk;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bits_r  <= 5'h00;
            shift_r <= 16'h0000;
        end else if (i_cs_n || rst_busy || cmd_done || data_done) begin
            bits_r  <= 5'h00;
            shift_r <= 16'h0000;
        end else if (rise) begin
            bits_r  <= bits_r + 5'h01;
            shift_r <= word_in;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmd_wr_r   <= 1'b0;
            cmd_addr_r <= 5'h00;
        end else if (cmd_done) begin
            cmd_wr_r   <= cmd_in[MM_CMD_WR_BIT];  // RULE_16
            cmd_addr_r <= cmd_in[4:0];
        end
    end

    // ------------------------------------------------------------
    // Read-back shifter
    // ------------------------------------------------------------
    // Unmapped addresses read as zero; read-back shows the live
    // register, so the conversion bit falls once the conversion ends.
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_r    <= 16'h0000;
            sdout_r <= 1'b0;
        end else if (cmd_done) begin
            tx_r <= (!cmd_in[MM_CMD_WR_BIT] && cmd_in[4:0] == MM_ADDR_MODE)
                    ? mode_r : 16'h0000;
        end else if (fall && state_r == MM_ST_DATA) begin
            sdout_r <= tx_r[15];
            tx_r    <= {tx_r[14:0], 1'b0};
        end else if (i_cs_n) begin
            sdout_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Operating configuration register
    // ------------------------------------------------------------
    assign go_thermal = mode_write & word_in[MM_THERMAL_CONVERT_GO];
    assign go_reset   = mode_write & word_in[MM_SOFT_CHIP_RESET];

    always_comb begin
        mode_nxt = mode_r;
        if (i_thermal_done) begin
            mode_nxt[MM_THERMAL_CONVERT_GO] = 1'b0;  // RULE_06
        end
        if (mode_write) begin
            // Test and reserved bits are kept for read-back only.
            mode_nxt = word_in;  // RULE_01 RULE_03 RULE_15 RULE_17
            mode_nxt[MM_SOFT_CHIP_RESET] = 1'b0;
            // A fresh start wins over a completion in the same cycle.
            if (!word_in[MM_THERMAL_CONVERT_GO]) begin
                mode_nxt[MM_THERMAL_CONVERT_GO] =
                    mode_r[MM_THERMAL_CONVERT_GO] & ~i_thermal_done;
            end
        end
        if (go_reset) begin
            mode_nxt = MM_MODE_RESET;  // RULE_07
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_r <= MM_MODE_RESET;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------
    // Soft reset hold-off
    // ------------------------------------------------------------
    // The hold time is rounded down, so the device is always ready
    // again by the time a host that waits 18 us starts talking.
    mm_hold_timer #(
        .CYCLES (SOFT_RST_CYC)
    ) u_rst_timer (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_start    (go_reset),
        .o_busy     (rst_busy)
    );  // RULE_07

    // ------------------------------------------------------------
    // Function controls
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pulse_r <= 1'b0;
            dip_r   <= 1'b0;
            start_r <= 1'b0;
        end else begin
            pulse_r <= i_power_pulse & ~mode_r[MM_PULSE_OUTPUT_OFF];  // RULE_04
            dip_r   <= i_dip_raw & ~mode_r[MM_DIP_DETECT_OFF];  // RULE_05
            start_r <= go_thermal & ~go_reset;  // RULE_06
        end
    end

    assign o_hp_filter_bypass     = mode_r[MM_HP_FILTER_BYPASS];  // RULE_02
    assign o_calibration_select   = mode_r[MM_CALIBRATION_SELECT];  // RULE_08
    assign o_conv1_inputs_shorted = mode_r[MM_CONV1_INPUTS_SHORT];  // RULE_09
    assign o_conv2_inputs_shorted = mode_r[MM_CONV2_INPUTS_SHORT];  // RULE_10
    assign o_channel_swap         = mode_r[MM_CHANNEL_SWAP];  // RULE_11
    assign o_power_freq_output    = pulse_r;
    assign o_dip_event            = dip_r;
    assign o_thermal_start        = start_r;
    assign o_soft_chip_reset      = rst_busy;
    assign o_sdout                = sdout_r;

    // ------------------------------------------------------------
    // Waveform register
    // ------------------------------------------------------------
    assign rate_sel     = mode_r[MM_RATE_SEL_LSB +: 2];
    assign ctl.rate_sel = rate_sel;  // RULE_12
    assign src_sel      = mode_r[MM_SOURCE_SEL_LSB +: 2];

    mm_rate_div u_rate_div (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .ctl        (ctl)
    );

    // The reserved source loads nothing, so the register holds its
    // last value and no new-data pulse is raised.
    assign src_sample = (src_sel == MM_SRC_CHAN1) ? i_chan1_sample :
                        (src_sel == MM_SRC_CHAN2) ? i_chan2_sample :
                                                    i_power_sample;  // RULE_14
    assign src_load   = ctl.tick && (src_sel != MM_SRC_RESERVED);  // RULE_14

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wave_r     <= '0;
            wave_new_r <= 1'b0;
        end else begin
            wave_new_r <= src_load;
            if (src_load) begin
                wave_r <= src_sample;  // RULE_13
            end
        end
    end

    assign o_waveform     = wave_r;
    assign o_waveform_new = wave_new_r;

endmodule

// *** hdl/mm_pkg.sv ***
// Constants and types shared by the mode configuration block.
package mm_pkg;

    // ------------------------------------------------------------
    // Register map and command byte
    // ------------------------------------------------------------
    localparam logic [4:0]  MM_ADDR_MODE   = 5'h06;
    localparam int          MM_CMD_WR_BIT  = 7;
    localparam int          MM_CMD_BITS    = 8;
    localparam int          MM_DATA_BITS   = 16;
    localparam logic [15:0] MM_MODE_RESET  = 16'h0000;

    // ------------------------------------------------------------
    // Field positions of the operating configuration register
    // ------------------------------------------------------------
    localparam int MM_HP_FILTER_BYPASS    = 0;
    localparam int MM_FACTORY_TEST_LOW    = 1;
    localparam int MM_PULSE_OUTPUT_OFF    = 2;
    localparam int MM_DIP_DETECT_OFF      = 3;
    localparam int MM_RESERVED_4          = 4;
    localparam int MM_THERMAL_CONVERT_GO  = 5;
    localparam int MM_SOFT_CHIP_RESET     = 6;
    localparam int MM_CALIBRATION_SELECT  = 7;
    localparam int MM_CONV1_INPUTS_SHORT  = 8;
    localparam int MM_CONV2_INPUTS_SHORT  = 9;
    localparam int MM_CHANNEL_SWAP        = 10;
    localparam int MM_RATE_SEL_LSB        = 11;
    localparam int MM_SOURCE_SEL_LSB      = 13;
    localparam int MM_FACTORY_TEST_HIGH   = 15;

    // ------------------------------------------------------------
    // Waveform rate and source encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MM_RATE_DIV128  = 2'h0;
    localparam logic [1:0] MM_RATE_DIV256  = 2'h1;
    localparam logic [1:0] MM_RATE_DIV512  = 2'h2;
    localparam logic [1:0] MM_RATE_DIV1024 = 2'h3;
    localparam logic [9:0] MM_MASK_DIV128  = 10'h07f;
    localparam logic [9:0] MM_MASK_DIV256  = 10'h0ff;
    localparam logic [9:0] MM_MASK_DIV512  = 10'h1ff;
    localparam logic [9:0] MM_MASK_DIV1024 = 10'h3ff;
    localparam logic [1:0] MM_SRC_POWER    = 2'h0;
    localparam logic [1:0] MM_SRC_RESERVED = 2'h1;
    localparam logic [1:0] MM_SRC_CHAN1    = 2'h2;
    localparam logic [1:0] MM_SRC_CHAN2    = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MM_CLK_PERIOD_NS = 20;
    localparam int MM_SOFT_RST_NS   = 18000;
    localparam int MM_SOFT_RST_CYC  = MM_SOFT_RST_NS / MM_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MM_ST_CMD,
        MM_ST_DATA,
        MM_ST_IGNORE
    } mm_state_t;

endpackage

// *** hdl/mm_rate_div.sv ***
// Waveform update rate divider producing a one-cycle tick.
`timescale 1ns/1ps
module mm_rate_div
    import mm_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    mm_ctl_if.div     ctl
);

    logic [9:0] cnt_r;
    logic       tick_r;
    logic [9:0] mask;
    logic       wrap;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // All ratios are powers of two, so one free counter serves them all.
    assign mask = (ctl.rate_sel == MM_RATE_DIV128) ? MM_MASK_DIV128 :
                  (ctl.rate_sel == MM_RATE_DIV256) ? MM_MASK_DIV256 :
                  (ctl.rate_sel == MM_RATE_DIV512) ? MM_MASK_DIV512 :
                                                     MM_MASK_DIV1024;
    assign wrap = &(cnt_r | ~mask);  // RULE_12
    assign ctl.tick = tick_r;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r  <= 10'h000;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_r + 10'h001;
            tick_r <= wrap;
        end
    end

endmodule

// *** sim/mm_host_model.sv ***
// Host controller model driving the serial link of the mode block.
`timescale 1ns/1ps
module mm_host_model #(
    parameter int GAP_CYC = mm_pkg::MM_SOFT_RST_CYC
) (
    input  wire logic i_core_clk,
    input  wire logic i_sdout,
    output logic      o_sclk,
    output logic      o_sdin,
    output logic      o_cs_n
);
    import mm_pkg::*;
    // ------------------------------------------------------------
    // Serial frames
    // ------------------------------------------------------------
    // Test and reserved bits always leave the host as zero.
    localparam logic [15:0] WR_MASK = 16'h7fed;
    initial begin
        o_sclk = 1'b0;
        o_sdin = 1'b0;
        o_cs_n = 1'b1;
    end
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] data,
                        output logic [15:0] rd);
        logic [23:0] frame;
        frame = {cmd, data & WR_MASK};
        rd = 16'h0000;
        @(negedge i_core_clk);
        o_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_sdin = frame[i];
            repeat (3) @(negedge i_core_clk);
            if (i < 16) begin
                rd[i] = i_sdout;
            end
            o_sclk = 1'b1;
            repeat (2) @(negedge i_core_clk);
        end
        o_sclk = 1'b0;
        repeat (2) @(negedge i_core_clk);
        o_cs_n = 1'b1;
        // A released data line must not keep looking like the last bit.
        o_sdin = ~o_sdin;
        repeat (2) @(negedge i_core_clk);
        if (cmd[MM_CMD_WR_BIT] && data[MM_SOFT_CHIP_RESET]) begin
            repeat (GAP_CYC) @(negedge i_core_clk);
        end
    endtask
endmodule

// *** sim/mm_mode_props.sv ***
// Concurrent checks on the ports of the mode configuration block.
`timescale 1ns/1ps
module mm_mode_props #(
    parameter int SOFT_RST_CYC = 900
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic o_sdout,
    input wire logic i_power_pulse,
    input wire logic i_dip_raw,
    input wire logic o_hp_filter_bypass,
    input wire logic o_power_freq_output,
    input wire logic o_dip_event,
    input wire logic o_thermal_start,
    input wire logic o_soft_chip_reset,
    input wire logic o_calibration_select,
    input wire logic o_channel_swap,
    input wire logic o_waveform_new
);
    // ------------------------------------------------------------
    // Soft reset length counter
    // ------------------------------------------------------------
    logic [15:0] srst_cnt_r;
    logic [15:0] srst_cnt_nxt;
    assign srst_cnt_nxt = o_soft_chip_reset ? srst_cnt_r + 16'h0001 : 16'h0000;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            srst_cnt_r <= 16'h0000;
        end else begin
            srst_cnt_r <= srst_cnt_nxt;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    a_pulse_gate: assert property (
        o_power_freq_output |-> $past(i_power_pulse))
        else $error("Pulse output seen without a raw pulse.");
    a_dip_gate: assert property (
        o_dip_event |-> $past(i_dip_raw))
        else $error("Dip event seen without a raw dip.");
    a_soft_len: assert property (
        $fell(o_soft_chip_reset) |-> srst_cnt_r == SOFT_RST_CYC)
        else $error("Soft reset level had the wrong length.");
    a_soft_bound: assert property (
        srst_cnt_r <= SOFT_RST_CYC)
        else $error("Soft reset level lasted too long.");
    a_soft_clear: assert property (
        o_soft_chip_reset && $past(o_soft_chip_reset) |->
        !o_hp_filter_bypass && !o_calibration_select && !o_channel_swap)
        else $error("Mode outputs active during soft reset.");
    a_thermal_pulse: assert property (
        o_thermal_start |=> !o_thermal_start)
        else $error("Thermal start longer than one cycle.");
    a_thermal_cause: assert property (
        $rose(o_thermal_start) |-> !$past(i_cs_n, 2))
        else $error("Thermal start without a frame.");
    a_wave_spacing: assert property (
        o_waveform_new |=> (!o_waveform_new) [*8])
        else $error("Waveform updates too close together.");
    a_sdout_idle: assert property (
        i_cs_n && $past(i_cs_n) |-> !o_sdout)
        else $error("Serial output driven outside a frame.");
    a_mode_hold: assert property (
        $changed(o_calibration_select) || $changed(o_channel_swap) |->
        !$past(i_cs_n))
        else $error("Mode output changed outside a frame.");
    c_soft_reset: cover property ($rose(o_soft_chip_reset));
    c_thermal: cover property (o_thermal_start);
    c_wave_new: cover property (o_waveform_new);
    c_read_one: cover property (!i_cs_n && o_sdout);
endmodule

bind mm_mode_top mm_mode_props #(.SOFT_RST_CYC(SOFT_RST_CYC)) u_props (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
    .o_sdout(o_sdout), .i_power_pulse(i_power_pulse),
    .i_dip_raw(i_dip_raw), .o_hp_filter_bypass(o_hp_filter_bypass),
    .o_power_freq_output(o_power_freq_output), .o_dip_event(o_dip_event),
    .o_thermal_start(o_thermal_start),
    .o_soft_chip_reset(o_soft_chip_reset),
    .o_calibration_select(o_calibration_select),
    .o_channel_swap(o_channel_swap), .o_waveform_new(o_waveform_new)
);

// *** sim/tb.sv ***
// Self-checking bench for the mode configuration block.
`timescale 1ns/1ps
module tb;
    import mm_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam int SW  = 24;
    localparam int SRC = 8;
    logic          clk, rst_n, sclk, sdin, cs_n, sdout, tdone, ppulse, dip;
    logic          hpf, pfo, dipo, tst, srst, cal, cv1, cv2, swp, wnew;
    logic [SW-1:0] psmp, c1smp, c2smp, wave;
    logic [15:0]   rd;
    logic [1:0]    srcs[3] = '{MM_SRC_CHAN1, MM_SRC_CHAN2, MM_SRC_POWER};
    int            bits[5] = '{0, 7, 8, 9, 10};
    int            n_errors = 0;
    int            comparisons = 0;
    int            n_therm = 0;
    int            n_srst = 0;
    int            n, base;
    wire [4:0]     outs = {swp, cv2, cv1, cal, hpf};
    mm_mode_top #(.SAMPLE_W(SW), .SOFT_RST_CYC(SRC)) u_dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_sdin(sdin),
        .i_cs_n(cs_n), .o_sdout(sdout), .i_thermal_done(tdone),
        .i_power_pulse(ppulse), .i_dip_raw(dip), .i_power_sample(psmp),
        .i_chan1_sample(c1smp), .i_chan2_sample(c2smp),
        .o_hp_filter_bypass(hpf), .o_power_freq_output(pfo),
        .o_dip_event(dipo), .o_thermal_start(tst), .o_soft_chip_reset(srst),
        .o_calibration_select(cal), .o_conv1_inputs_shorted(cv1),
        .o_conv2_inputs_shorted(cv2), .o_channel_swap(swp),
        .o_waveform(wave), .o_waveform_new(wnew)
    );
    mm_host_model #(.GAP_CYC(SRC + 4)) u_host (
        .i_core_clk(clk), .i_sdout(sdout), .o_sclk(sclk), .o_sdin(sdin),
        .o_cs_n(cs_n)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) begin
        n_therm += (tst === 1'b1) ? 1 : 0;
        n_srst += (srst === 1'b1) ? 1 : 0;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] addr, input logic [15:0] data);
        u_host.xfer({1'b1, 2'b00, addr}, data, rd);
    endtask
    task automatic rd_chk(input logic [4:0] addr, input logic [15:0] exp,
                          input string name);
        u_host.xfer({1'b0, 2'b00, addr}, 16'h0000, rd);
        chk(name, 24'(exp), 24'(rd));
    endtask
    task automatic wait_new();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wnew !== 1'b1 && n < 3000);
        if (wnew !== 1'b1) begin
            n_errors++;
            test_done();
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        tdone = 1'b0;
        ppulse = 1'b0;
        dip = 1'b0;
        psmp = 24'h11_1111;
        c1smp = 24'h22_2222;
        c2smp = 24'h33_3333;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(MM_ADDR_MODE, MM_MODE_RESET, "mode reset");
        for (int k = 0; k < 5; k++) begin
            wr(MM_ADDR_MODE, 16'(1 << bits[k]));
            chk("outs", 24'(1 << k), 24'(outs));
            rd_chk(MM_ADDR_MODE, 16'(1 << bits[k]), "mode read");
        end
        ppulse = 1'b1;
        dip = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr(MM_ADDR_MODE, 16'h0000);
            chk("gates open", 24'h00_0003, 24'({pfo, dipo}));
            wr(MM_ADDR_MODE, 16'(4 << k));
            chk("gates shut", 24'(1 << k), 24'({pfo, dipo}));
        end
        ppulse = 1'b0;
        dip = 1'b0;
        base = n_therm;
        wr(MM_ADDR_MODE, 16'h0020);
        chk("thermal start", 24'h00_0001, 24'(n_therm - base));
        rd_chk(MM_ADDR_MODE, 16'h0020, "thermal busy");
        tdone = 1'b1;
        @(negedge clk);
        tdone = 1'b0;
        rd_chk(MM_ADDR_MODE, 16'h0000, "thermal clear");
        wr(MM_ADDR_MODE, 16'h0481);
        base = n_srst;
        wr(MM_ADDR_MODE, 16'h0040);
        chk("soft len", 24'(SRC), 24'(n_srst - base));
        chk("soft outs", 24'h00_0000, 24'({outs, srst}));
        rd_chk(MM_ADDR_MODE, 16'h0000, "soft mode");
        wr(5'h07, 16'h0481);
        rd_chk(MM_ADDR_MODE, 16'h0000, "foreign write");
        rd_chk(5'h07, 16'h0000, "foreign read");
        for (int r = 0; r < 4; r++) begin
            wr(MM_ADDR_MODE, {1'b0, MM_SRC_CHAN1, 2'(r), 11'h000});
            wait_new();
            wait_new();
            chk("update gap", 24'(128 << r), 24'(n));
        end
        for (int s = 0; s < 3; s++) begin
            wr(MM_ADDR_MODE, {1'b0, srcs[s], 13'h0000});
            wait_new();
            wait_new();
            chk("wave", s == 0 ? c1smp : s == 1 ? c2smp : psmp, wave);
        end
        // Reserved source keeps the last sample.
        wr(MM_ADDR_MODE, {1'b0, MM_SRC_RESERVED, 13'h0000});
        psmp = 24'h44_4444;
        repeat (300) @(negedge clk);
        chk("wave reserved", 24'h11_1111, wave);
        test_done();
    end
endmodule
